//--- hw/irq_wake_defs.svh
// Offsets, field positions, reset values and encodings of the interrupt and wake block.
`ifndef IRQ_WAKE_DEFS_SVH
`define IRQ_WAKE_DEFS_SVH

// Vector table shape: ten vectors eight bytes apart from the first entry.
`define IRQ_NUM_VEC      10
`define IRQ_VEC_BASE     8'h03
`define IRQ_VEC_LAST     8'h4b
`define IRQ_TOP_VEC_CNT  2

// Priority level codes, ordered so that a larger code outranks a smaller one.
`define LVL_NONE         2'h0
`define LVL_LOW          2'h1
`define LVL_HIGH         2'h2
`define LVL_TOP          2'h3

// Register byte offsets on the plain register port.
`define REG_PRIO         8'h00
`define REG_VEC_EN       8'h04
`define REG_CTRL         8'h08
`define REG_STANDBY      8'h0c
`define REG_STATUS       8'h10
`define REG_WAKE_CAUSE   8'h14

// Reset values.
`define PRIO_RST         10'h000
`define VEC_EN_RST       10'h000
`define CTRL_RST         2'h2
`define WAKE_CAUSE_RST   6'h00

// Control register fields.
`define CTRL_GIE_BIT     0
`define CTRL_XTAL_BIT    1

// Standby command codes written to the standby register.
`define SBY_CMD_NONE     2'h0
`define SBY_CMD_HALT     2'h1
`define SBY_CMD_HOLD     2'h2
`define SBY_CMD_XHOLD    2'h3

// Wake cause bit positions.
`define WAKE_EXT_BIT     0
`define WAKE_PORT_BIT    1
`define WAKE_USB_BIT     2
`define WAKE_BASE_BIT    3
`define WAKE_REMOTE_BIT  4
`define WAKE_IRQ_BIT     5

// Status register field positions.
`define STAT_ISV_LSB     16
`define STAT_STATE_LSB   24

`endif

//--- hw/irq_wake_pkg.sv
// Types shared by the interrupt arbiter and standby wake controller.
package irq_wake_pkg;

  // Standby state, one-hot.
  typedef enum logic [3:0] {
    SBY_RUN   = 4'b0001,
    SBY_HALT  = 4'b0010,
    SBY_HOLD  = 4'b0100,
    SBY_XHOLD = 4'b1000
  } sby_e;

  // Granted priority level as seen by the core.
  typedef enum logic [1:0] {
    LEVEL_NONE = 2'h0,
    LEVEL_LOW  = 2'h1,
    LEVEL_HIGH = 2'h2,
    LEVEL_TOP  = 2'h3
  } level_e;

  // Request lines that arrive from device pins.
  typedef struct packed {
    logic ext_irq_a;
    logic ext_irq_b;
    logic ext_irq_c;
    logic ext_irq_d;
    logic ext_irq_e;
    logic ext_irq_f;
    logic ext_irq_g;
    logic ext_irq_h;
    logic port_zero;
  } pin_irq_s;

  // Request lines from on-chip peripherals, all on the system clock.
  typedef struct packed {
    logic timer_zero_low_half;
    logic timer_zero_high_half;
    logic usb_host_ctrl_bus_active;
    logic remote_rx;
    logic base_timer;
    logic usb_host_ctrl_attach;
    logic usb_host_ctrl_detach;
    logic usb_host_ctrl_resume;
    logic timer_one_low;
    logic timer_one_high;
    logic ser_sync_c;
    logic audio_start;
    logic ser_sync_a;
    logic uart_rx;
    logic ser_mixed;
    logic ser_sync_b;
    logic uart_tx;
    logic audio_end;
    logic adc_done;
    logic timer_six;
    logic timer_seven;
    logic usb_host_ctrl_ack;
    logic usb_host_ctrl_nak;
    logic usb_host_ctrl_err;
    logic usb_host_ctrl_stall;
    logic pwm_zero;
    logic pwm_one;
    logic timer_four;
    logic timer_five;
    logic usb_host_ctrl_sof;
    logic dma_copy;
    logic audio_err;
  } periph_irq_s;

  // Oscillator stop requests.
  typedef struct packed {
    logic pll_ref;
    logic ceramic;
    logic rc;
    logic xtal;
  } osc_stop_s;

endpackage : irq_wake_pkg

//--- hw/priority_irq_and_standby_wake.sv
// Nested three-level interrupt arbiter with halt, hold and crystal-hold standby control.
//
// Overview of operation
// RULE1: Three priority levels exist, top above high above low.
// RULE2: Requests at or below the highest level in service are refused.
// RULE3: Among simultaneous vector requests the highest level wins.
// RULE4: Among equal levels the lowest vector address wins.
// RULE5: Forty-one sources feed ten vectors, 03h to 4bh, eight bytes apart.
// RULE6: Vector 13h collects ext_irq_c, timer zero low, ext_irq_e, USB bus active, remote.
// RULE7: Vector 23h collects timer zero high, ext_irq_g, USB attach, detach, resume.
// RULE8: Only the first two vectors may be top level; others high or low.
// RULE9: Halt stops execution, peripherals keep running, oscillators stay on.
// RULE10: Halt ends on pin reset, watchdog reset or an accepted interrupt.
// RULE11: Hold stops execution, all peripherals and all four oscillators.
// RULE12: Hold ends on resets, pins a b c e f, port zero, USB bus active.
// RULE13: Software sets ext_irq_a and ext_irq_b to level detection for hold wake.
// RULE14: Crystal hold stops execution, peripherals but base timer, PLL, ceramic, RC.
// RULE15: Crystal hold keeps the crystal oscillator as it was on entry.
// RULE16: Crystal hold also ends on base timer or remote receiver interrupts.
// RULE17: After an interrupt wake, execution resumes and normal arbitration applies.
//
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "irq_wake_defs.svh"

module priority_irq_and_standby_wake
  import irq_wake_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  input  wire logic        i_wdt_rst,
  input  wire pin_irq_s    i_pin_irq,
  input  wire periph_irq_s i_periph_irq,
  input  wire logic        i_irq_ack,
  input  wire logic        i_irq_ret,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr_stb,
  input  wire logic        i_rd_stb,
  output logic [31:0]      o_rdata,
  output logic             o_irq_req,
  output logic [7:0]       o_irq_vector,
  output level_e           o_irq_level,
  output logic             o_cpu_stop,
  output logic             o_periph_stop,
  output logic             o_base_timer_stop,
  output osc_stop_s        o_osc_stop
);

  // Watchdog reset clears the block exactly as the pin reset does.
  logic rst_all;
  assign rst_all = i_rst | i_wdt_rst; // [RULE10] [RULE12] [RULE16]

  // Registers.
  pin_irq_s    pin_meta_reg;
  pin_irq_s    pin_sync_reg;
  logic [9:0]  prio_reg;
  logic [9:0]  vec_en_reg;
  logic [1:0]  ctrl_reg;
  logic [5:0]  wake_cause_reg;
  logic [5:0]  wake_cause_next;
  logic [2:0]  isv_reg;
  logic [2:0]  isv_next;
  sby_e        state_reg;
  sby_e        state_next;
  logic        grant_valid_reg;
  logic        grant_valid_next;
  logic [7:0]  grant_vec_reg;
  logic [1:0]  grant_lvl_reg;
  osc_stop_s   osc_stop_reg;
  osc_stop_s   osc_stop_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  // Pin requests pass two flops; only the second stage is read by logic.
  always_ff @(posedge i_ref_clk) begin
    if (rst_all) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
    end else begin
      pin_meta_reg <= i_pin_irq;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // Register port decode.
  wire wr_prio    = i_wr_stb && (i_addr == `REG_PRIO);
  wire wr_vec_en  = i_wr_stb && (i_addr == `REG_VEC_EN);
  wire wr_ctrl    = i_wr_stb && (i_addr == `REG_CTRL);
  wire wr_standby = i_wr_stb && (i_addr == `REG_STANDBY);
  wire wr_wake    = i_wr_stb && (i_addr == `REG_WAKE_CAUSE);
  wire gie        = ctrl_reg[`CTRL_GIE_BIT];
  wire xtal_en    = ctrl_reg[`CTRL_XTAL_BIT];
  wire [1:0] sby_cmd = i_wdata[1:0];

  // Source grouping onto the ten vectors; the pin groups use synchronised copies.
  logic [9:0] vec_pend;
  assign vec_pend[0] = pin_sync_reg.ext_irq_a; // [RULE5]
  assign vec_pend[1] = pin_sync_reg.ext_irq_b; // [RULE5]
  assign vec_pend[2] = pin_sync_reg.ext_irq_c | i_periph_irq.timer_zero_low_half
                     | pin_sync_reg.ext_irq_e | i_periph_irq.usb_host_ctrl_bus_active
                     | i_periph_irq.remote_rx; // [RULE6]
  assign vec_pend[3] = pin_sync_reg.ext_irq_d | pin_sync_reg.ext_irq_f
                     | i_periph_irq.base_timer; // [RULE5]
  assign vec_pend[4] = i_periph_irq.timer_zero_high_half | pin_sync_reg.ext_irq_g
                     | i_periph_irq.usb_host_ctrl_attach | i_periph_irq.usb_host_ctrl_detach
                     | i_periph_irq.usb_host_ctrl_resume; // [RULE7]
  assign vec_pend[5] = i_periph_irq.timer_one_low | i_periph_irq.timer_one_high
                     | pin_sync_reg.ext_irq_h | i_periph_irq.ser_sync_c
                     | i_periph_irq.audio_start; // [RULE5]
  assign vec_pend[6] = i_periph_irq.ser_sync_a | i_periph_irq.uart_rx; // [RULE5]
  assign vec_pend[7] = i_periph_irq.ser_mixed | i_periph_irq.ser_sync_b
                     | i_periph_irq.uart_tx | i_periph_irq.audio_end; // [RULE5]
  assign vec_pend[8] = i_periph_irq.adc_done | i_periph_irq.timer_six
                     | i_periph_irq.timer_seven | i_periph_irq.usb_host_ctrl_ack
                     | i_periph_irq.usb_host_ctrl_nak | i_periph_irq.usb_host_ctrl_err
                     | i_periph_irq.usb_host_ctrl_stall; // [RULE5]
  assign vec_pend[9] = pin_sync_reg.port_zero | i_periph_irq.pwm_zero
                     | i_periph_irq.pwm_one | i_periph_irq.timer_four
                     | i_periph_irq.timer_five | i_periph_irq.usb_host_ctrl_sof
                     | i_periph_irq.dma_copy | i_periph_irq.audio_err; // [RULE5]

  // Highest level currently in service; bit 2 top, bit 1 high, bit 0 low.
  logic [1:0] cur_lvl;
  assign cur_lvl = isv_reg[2] ? `LVL_TOP :
                   isv_reg[1] ? `LVL_HIGH :
                   isv_reg[0] ? `LVL_LOW : `LVL_NONE; // [RULE1]

  // Per-vector level and eligibility. A single raise bit per vector means an
  // illegal level cannot be programmed at all, so no check is needed later.
  logic [1:0] vec_lvl [`IRQ_NUM_VEC];
  logic [9:0] vec_elig;
  genvar gv;
  generate
    for (gv = 0; gv < `IRQ_NUM_VEC; gv++) begin : g_vec
      assign vec_lvl[gv] = !prio_reg[gv] ? `LVL_LOW :
                           (gv < `IRQ_TOP_VEC_CNT) ? `LVL_TOP : `LVL_HIGH; // [RULE8]
      assign vec_elig[gv] = vec_pend[gv] && vec_en_reg[gv] && gie
                            && (vec_lvl[gv] > cur_lvl); // [RULE2]
    end
  endgenerate

  // Arbitration: scanning from the last vector down and taking equal levels
  // lets the lowest address win a tie while a higher level always wins.
  logic [1:0] best_lvl;
  logic [3:0] best_idx;
  logic       best_ok;
  always_comb begin
    best_lvl = `LVL_NONE;
    best_idx = 4'h0;
    best_ok  = 1'b0;
    for (int i = `IRQ_NUM_VEC - 1; i >= 0; i--) begin
      if (vec_elig[i] && (vec_lvl[i] >= best_lvl)) begin // [RULE3] [RULE4]
        best_ok  = 1'b1;
        best_lvl = vec_lvl[i];
        best_idx = 4'(i);
      end
    end
  end

  // Vector address is the base plus eight times the vector index.
  wire [7:0] best_addr = `IRQ_VEC_BASE + {1'b0, best_idx, 3'b000}; // [RULE5]

  // In-service stack: a return pops the highest level, an acknowledge pushes
  // the granted level. Both in one cycle pop first, then push.
  wire [2:0] isv_top  = {isv_reg[2], isv_reg[1] & ~isv_reg[2],
                         isv_reg[0] & ~isv_reg[1] & ~isv_reg[2]};
  wire [2:0] isv_pop  = i_irq_ret ? (isv_reg & ~isv_top) : isv_reg;
  wire       push     = i_irq_ack && grant_valid_reg;
  wire [2:0] push_msk = {grant_lvl_reg == `LVL_TOP, grant_lvl_reg == `LVL_HIGH,
                         grant_lvl_reg == `LVL_LOW};
  assign isv_next = push ? (isv_pop | push_msk) : isv_pop; // [RULE2]

  // A grant is offered only while running, and is withdrawn on the acknowledge
  // edge so that the core never sees the same request twice. A standby entry
  // also blocks it, so no request is shown in the first stopped cycle.
  wire run = (state_reg == SBY_RUN);
  assign grant_valid_next = best_ok && run && (state_next == SBY_RUN)
                            && !i_irq_ack; // [RULE17]

  // Wake sources. ext_irq_a and ext_irq_b are read as plain levels here, so the
  // pins must be set for level detection for the wake to be dependable.
  wire ext_wake  = (pin_sync_reg.ext_irq_a & vec_en_reg[0])
                 | (pin_sync_reg.ext_irq_b & vec_en_reg[1])
                 | ((pin_sync_reg.ext_irq_c | pin_sync_reg.ext_irq_e) & vec_en_reg[2])
                 | (pin_sync_reg.ext_irq_f & vec_en_reg[3]); // [RULE12] [RULE13]
  wire port_wake = pin_sync_reg.port_zero & vec_en_reg[9]; // [RULE12]
  wire usb_wake  = i_periph_irq.usb_host_ctrl_bus_active & vec_en_reg[2]; // [RULE12]
  wire base_wake = i_periph_irq.base_timer & vec_en_reg[3]; // [RULE16]
  wire rmt_wake  = i_periph_irq.remote_rx & vec_en_reg[2]; // [RULE16]
  wire hold_wake  = ext_wake | port_wake | usb_wake; // [RULE12]
  wire xhold_wake = hold_wake | base_wake | rmt_wake; // [RULE16]

  // Standby state machine. Commands are honoured only while running.
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      SBY_RUN: begin
        if (wr_standby) begin
          unique case (sby_cmd)
            `SBY_CMD_HALT:  state_next = SBY_HALT;
            `SBY_CMD_HOLD:  state_next = SBY_HOLD;
            `SBY_CMD_XHOLD: state_next = SBY_XHOLD;
            `SBY_CMD_NONE:  state_next = SBY_RUN;
          endcase
        end
      end
      SBY_HALT: begin
        if (best_ok) state_next = SBY_RUN; // [RULE10]
      end
      SBY_HOLD: begin
        if (hold_wake) state_next = SBY_RUN; // [RULE12] [RULE17]
      end
      SBY_XHOLD: begin
        if (xhold_wake) state_next = SBY_RUN; // [RULE16] [RULE17]
      end
      default: state_next = SBY_RUN;
    endcase
  end

  // Oscillator stops follow the next state so they line up with state_reg.
  // Halt leaves every oscillator alone; crystal hold freezes the crystal.
  wire nx_hold  = (state_next == SBY_HOLD);
  wire nx_xhold = (state_next == SBY_XHOLD);
  assign osc_stop_next.pll_ref = nx_hold | nx_xhold; // [RULE9] [RULE11] [RULE14]
  assign osc_stop_next.ceramic = nx_hold | nx_xhold; // [RULE11] [RULE14]
  assign osc_stop_next.rc      = nx_hold | nx_xhold; // [RULE11] [RULE14]
  assign osc_stop_next.xtal    = nx_hold ? 1'b1 :
                                 nx_xhold ? osc_stop_reg.xtal : !xtal_en; // [RULE11] [RULE15]

  // Wake causes are sticky; a new cause wins over a same-cycle clear.
  logic [5:0] wake_set;
  assign wake_set[`WAKE_EXT_BIT]    = !run && !(state_reg == SBY_HALT) && ext_wake;
  assign wake_set[`WAKE_PORT_BIT]   = !run && !(state_reg == SBY_HALT) && port_wake;
  assign wake_set[`WAKE_USB_BIT]    = !run && !(state_reg == SBY_HALT) && usb_wake;
  assign wake_set[`WAKE_BASE_BIT]   = (state_reg == SBY_XHOLD) && base_wake;
  assign wake_set[`WAKE_REMOTE_BIT] = (state_reg == SBY_XHOLD) && rmt_wake;
  assign wake_set[`WAKE_IRQ_BIT]    = (state_reg == SBY_HALT) && best_ok;
  assign wake_cause_next = (wake_cause_reg & ~(wr_wake ? i_wdata[5:0] : 6'h00)) | wake_set;

  // Read mux; unmapped offsets read zero.
  wire [31:0] status_word = {4'h0, state_reg, 5'h00, isv_reg, 6'h00, vec_pend};
  assign rdata_next = !i_rd_stb                     ? 32'h0000_0000 :
                      (i_addr == `REG_PRIO)         ? {22'h000000, prio_reg} :
                      (i_addr == `REG_VEC_EN)       ? {22'h000000, vec_en_reg} :
                      (i_addr == `REG_CTRL)         ? {30'h00000000, ctrl_reg} :
                      (i_addr == `REG_STANDBY)      ? {28'h0000000, state_reg} :
                      (i_addr == `REG_STATUS)       ? status_word :
                      (i_addr == `REG_WAKE_CAUSE)   ? {26'h0000000, wake_cause_reg} :
                                                      32'h0000_0000;

  // Software registers.
  always_ff @(posedge i_ref_clk) begin
    if (rst_all) begin
      prio_reg       <= `PRIO_RST;
      vec_en_reg     <= `VEC_EN_RST;
      ctrl_reg       <= `CTRL_RST;
      wake_cause_reg <= `WAKE_CAUSE_RST;
      rdata_reg      <= 32'h0000_0000;
    end else begin
      if (wr_prio) prio_reg <= i_wdata[9:0];
      if (wr_vec_en) vec_en_reg <= i_wdata[9:0];
      if (wr_ctrl) ctrl_reg <= i_wdata[1:0];
      wake_cause_reg <= wake_cause_next;
      rdata_reg      <= rdata_next;
    end
  end

  // Arbitration and standby state.
  always_ff @(posedge i_ref_clk) begin
    if (rst_all) begin
      isv_reg         <= 3'h0;
      state_reg       <= SBY_RUN;
      grant_valid_reg <= 1'b0;
      grant_vec_reg   <= `IRQ_VEC_BASE;
      grant_lvl_reg   <= `LVL_NONE;
      osc_stop_reg    <= '0;
    end else begin
      isv_reg         <= isv_next;
      state_reg       <= state_next;
      grant_valid_reg <= grant_valid_next;
      grant_vec_reg   <= best_addr;
      grant_lvl_reg   <= best_lvl;
      osc_stop_reg    <= osc_stop_next;
    end
  end

  // Outputs; the core, peripheral and base timer stop lines are decoded from the state register, the oscillator stops come from osc_stop_reg.
  assign o_rdata           = rdata_reg;
  assign o_irq_req         = grant_valid_reg;
  assign o_irq_vector      = grant_vec_reg;
  assign o_irq_level       = level_e'(grant_lvl_reg);
  assign o_cpu_stop        = !run; // [RULE9] [RULE11] [RULE14]
  assign o_periph_stop     = (state_reg == SBY_HOLD) | (state_reg == SBY_XHOLD); // [RULE14]
  assign o_base_timer_stop = (state_reg == SBY_HOLD); // [RULE11] [RULE14]
  assign o_osc_stop        = osc_stop_reg;

endmodule : priority_irq_and_standby_wake
`default_nettype wire

//--- verif/core_model.sv
// Behavioural processor core that takes offered vectors and returns from service.
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  input  wire logic       i_irq_req,
  input  wire logic       i_take,
  input  wire logic       i_ret_req,
  input  wire logic [3:0] i_dly,
  output logic            o_irq_ack,
  output logic            o_irq_ret
);
  logic [3:0] wait_reg;
  wire logic  ready = i_take && i_irq_req && !o_irq_ack;
  // Ack only an offered vector, after i_dly idle cycles, so slow cores are seen too.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_irq_ack <= 1'b0;
      o_irq_ret <= 1'b0;
      wait_reg  <= 4'h0;
    end else begin
      o_irq_ret <= i_ret_req;
      o_irq_ack <= ready && wait_reg >= i_dly;
      wait_reg  <= ready ? wait_reg + 4'h1 : 4'h0;
    end
  end
endmodule : core_model
`default_nettype wire

//--- verif/priority_irq_and_standby_wake_sva.sv
// Port checks of the interrupt arbiter and standby controller.
`timescale 1ns/1ps
`default_nettype none
module priority_irq_and_standby_wake_sva
  import irq_wake_pkg::*;
(
  input wire logic        i_ref_clk,
  input wire logic        i_rst,
  input wire logic        i_wdt_rst,
  input wire pin_irq_s    i_pin_irq,
  input wire periph_irq_s i_periph_irq,
  input wire logic        i_irq_ack,
  input wire logic        i_irq_ret,
  input wire logic [7:0]  i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr_stb,
  input wire logic        i_rd_stb,
  input wire logic [31:0] o_rdata,
  input wire logic        o_irq_req,
  input wire logic [7:0]  o_irq_vector,
  input wire level_e      o_irq_level,
  input wire logic        o_cpu_stop,
  input wire logic        o_periph_stop,
  input wire logic        o_base_timer_stop,
  input wire osc_stop_s   o_osc_stop
);
  // Crystal hold is the only state that stops peripherals but not the base timer.
  wire logic xh = o_periph_stop && !o_base_timer_stop;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  req_has_level_a: assert property (o_irq_req |-> o_irq_level != LEVEL_NONE)
    else $error("request without level");
  ack_refuse_a: assert property (o_irq_req && i_irq_ack |=> !o_irq_req)
    else $error("request held after ack");
  vec_grid_a: assert property (o_irq_req |-> o_irq_vector inside {[8'h03:8'h4b]}
    && o_irq_vector[2:0] == 3'h3) else $error("vector off grid");
  top_only_a: assert property (o_irq_req && o_irq_level == LEVEL_TOP |->
    o_irq_vector inside {8'h03, 8'h0b}) else $error("top level on wrong vector");
  stop_no_req_a: assert property (o_cpu_stop |-> !o_irq_req)
    else $error("request while stopped");
  wdt_wake_a: assert property (i_wdt_rst |=> !o_cpu_stop && o_osc_stop == 4'h0)
    else $error("watchdog did not end standby");
  halt_osc_a: assert property (o_cpu_stop && !o_periph_stop |->
    o_osc_stop[3:1] == 3'h0 && !o_base_timer_stop) else $error("halt stopped clocks");
  hold_osc_a: assert property (o_base_timer_stop |-> o_periph_stop && o_cpu_stop
    && o_osc_stop == 4'hf) else $error("hold clocks wrong");
  xhold_osc_a: assert property (xh |-> o_cpu_stop && o_osc_stop[3:1] == 3'h7)
    else $error("crystal hold clocks wrong");
  xtal_keep_a: assert property (xh && $past(xh) |-> $stable(o_osc_stop.xtal))
    else $error("crystal state changed in hold");
  ack_c: cover property (o_irq_req && i_irq_ack);
  hold_c: cover property (o_base_timer_stop);
  xhold_c: cover property (xh);
  halt_c: cover property (o_cpu_stop && !o_periph_stop);
endmodule : priority_irq_and_standby_wake_sva
bind priority_irq_and_standby_wake priority_irq_and_standby_wake_sva
  priority_irq_and_standby_wake_sva_i (.i_ref_clk, .i_rst, .i_wdt_rst, .i_pin_irq,
  .i_periph_irq, .i_irq_ack, .i_irq_ret, .i_addr, .i_wdata, .i_wr_stb, .i_rd_stb, .o_rdata,
  .o_irq_req, .o_irq_vector, .o_irq_level, .o_cpu_stop, .o_periph_stop, .o_base_timer_stop,
  .o_osc_stop);
`default_nettype wire

//--- verif/priority_irq_and_standby_wake_tb.sv
// Self-checking bench of the interrupt arbiter and standby controller.
`timescale 1ns/1ps
`default_nettype none
`include "irq_wake_defs.svh"
module priority_irq_and_standby_wake_tb
  import irq_wake_pkg::*;
;
  logic        i_ref_clk = 1'b0, i_rst = 1'b1, i_wdt_rst = 1'b0, take = 1'b0, ret_req = 1'b0;
  logic        i_wr_stb = 1'b0, i_rd_stb = 1'b0;
  logic [7:0]  i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0, o_rdata, seed = 32'he2b60846, a, b;
  logic [3:0]  dly = 4'h0;
  pin_irq_s    i_pin_irq = '0;
  periph_irq_s i_periph_irq = '0;
  wire logic   i_irq_ack, i_irq_ret, o_irq_req, o_cpu_stop, o_periph_stop, o_base_timer_stop;
  wire logic [7:0] o_irq_vector;
  level_e      o_irq_level;
  osc_stop_s   o_osc_stop;
  logic [9:0]  pr, m;
  logic [5:0]  e;
  int          bad_count = 0, cmp_count = 0;
  // Vector index of each peripheral bit, then of each pin bit, from bit 0 up.
  int pv[32] = '{9,9,9,9,9,9,9,8,8,8,8,8,8,8,7,7,7,7,6,6,5,5,5,5,4,4,4,3,2,2,4,2};
  int qv[9] = '{9,5,4,3,2,3,2,1,0};
  wire logic [6:0] stops = {o_cpu_stop, o_periph_stop, o_base_timer_stop, o_osc_stop};
  always #50 i_ref_clk = ~i_ref_clk;
  priority_irq_and_standby_wake priority_irq_and_standby_wake_i (.i_ref_clk, .i_rst,
    .i_wdt_rst, .i_pin_irq, .i_periph_irq, .i_irq_ack, .i_irq_ret, .i_addr, .i_wdata,
    .i_wr_stb, .i_rd_stb, .o_rdata, .o_irq_req, .o_irq_vector, .o_irq_level, .o_cpu_stop,
    .o_periph_stop, .o_base_timer_stop, .o_osc_stop);
  core_model core_model_i (.i_ref_clk, .i_rst, .i_irq_req(o_irq_req), .i_take(take),
    .i_ret_req(ret_req), .i_dly(dly), .o_irq_ack(i_irq_ack), .o_irq_ret(i_irq_ret));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  // Model: winning level and vector index of the pending set, ties to the lowest index.
  function automatic logic [5:0] best(input logic [9:0] mk, input logic [9:0] p);
    int lv, bl, bi;
    bl = 0;
    bi = 0;
    for (int i = 0; i < 10; i++) begin
      lv = !p[i] ? 1 : (i < 2 ? 3 : 2);
      if (mk[i] && lv > bl) begin
        bl = lv;
        bi = i;
      end
    end
    return {bl[1:0], bi[3:0]};
  endfunction : best
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test
  task automatic cmp_port(input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : cmp_port
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_wr_stb <= 1'b1;
    i_addr <= ad;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr_stb <= 1'b0;
    #1;
  endtask : wr
  // Read data stand only in the cycle after the strobe, so they are sampled there.
  task automatic cmp_reg(input logic [7:0] ad, input logic [31:0] exp);
    @(posedge i_ref_clk);
    i_rd_stb <= 1'b1;
    i_addr <= ad;
    @(posedge i_ref_clk);
    i_rd_stb <= 1'b0;
    #1;
    cmp_port(exp, o_rdata);
  endtask : cmp_reg
  // Bounded wait: 0 offered vector, 1 core running, 2 core ack.
  task automatic wait_for(input int sel);
    int n;
    n = 0;
    while ((sel == 0 ? o_irq_req : sel == 1 ? !o_cpu_stop : i_irq_ack) !== 1'b1 && n < 20) begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end
    if (n == 20) begin
      cmp_port(32'h1, 32'h0);
      finish_test();
    end
  endtask : wait_for
  task automatic serve();
    take <= 1'b1;
    wait_for(2);
    take <= 1'b0;
  endtask : serve
  task automatic quiet_ret(input int cnt);
    i_periph_irq <= '0;
    i_pin_irq <= '0;
    repeat (4) @(posedge i_ref_clk);
    repeat (cnt) begin
      ret_req <= 1'b1;
      @(posedge i_ref_clk);
      ret_req <= 1'b0;
      @(posedge i_ref_clk);
    end
    #1;
  endtask : quiet_ret
  initial begin
    repeat (10) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    #1;
    cmp_port(32'h600, {14'h0, o_irq_req, o_irq_vector, o_irq_level, stops});
    cmp_reg(`REG_CTRL, 32'h2);
    cmp_reg(8'h20, 32'h0);
    cmp_reg(`REG_STANDBY, 32'h1);
    $display("reset test done");
    wr(`REG_VEC_EN, 32'h3ff);
    wr(`REG_CTRL, 32'h3);
    // Random sources on all vectors and levels; pins stay levels for hold wake.
    for (int k = 0; k < 24; k++) begin
      a = lfsr(seed);
      b = lfsr(a);
      seed = lfsr(b);
      pr = a[9:0];
      wr(`REG_PRIO, {22'h0, pr});
      i_periph_irq <= a & b & seed | 32'h1;
      i_pin_irq <= a[8:0] & b[17:9];
      #1;
      m = 10'h0;
      for (int i = 0; i < 32; i++) m[pv[i]] |= i_periph_irq[i];
      for (int i = 0; i < 9; i++) m[qv[i]] |= i_pin_irq[i];
      e = best(m, pr);
      wait_for(0);
      repeat (3) @(posedge i_ref_clk);
      #1;
      cmp_port({e[3:0], 3'h3}, o_irq_vector);
      cmp_port(e[5:4], o_irq_level);
      dly <= 4'(k % 3);
      serve();
      cmp_reg(`REG_STATUS, {13'h20, 3'h1 << (e[5:4] - 2'h1), 6'h0, m});
      quiet_ret(1);
    end
    $display("arbitration test done");
    wr(`REG_PRIO, 32'h0);
    i_periph_irq.timer_six <= 1'b1;
    wait_for(0);
    cmp_port(32'h143, {o_irq_level, o_irq_vector});
    serve();
    i_periph_irq <= 32'h0004_0000; // Only the receive source of the low vector.
    repeat (5) @(posedge i_ref_clk);
    #1;
    cmp_port(32'h0, o_irq_req);
    wr(`REG_PRIO, 32'h40);
    wait_for(0);
    cmp_port(32'h233, {o_irq_level, o_irq_vector});
    serve();
    cmp_reg(`REG_STATUS, 32'h1030040);
    quiet_ret(2);
    $display("nesting test done");
    wr(`REG_STANDBY, {30'h0, `SBY_CMD_HALT});
    cmp_port(32'h40, stops);
    i_periph_irq.adc_done <= 1'b1;
    wait_for(1);
    wait_for(0);
    cmp_port(32'h43, o_irq_vector);
    cmp_reg(`REG_WAKE_CAUSE, 32'h20);
    wr(`REG_WAKE_CAUSE, 32'h3f);
    quiet_ret(0);
    wr(`REG_STANDBY, {30'h0, `SBY_CMD_HOLD});
    cmp_port(32'h7f, stops);
    i_periph_irq.base_timer <= 1'b1;
    repeat (6) @(posedge i_ref_clk);
    #1;
    cmp_port(32'h1, o_cpu_stop);
    i_pin_irq.port_zero <= 1'b1;
    wait_for(1);
    cmp_reg(`REG_WAKE_CAUSE, 32'h2);
    quiet_ret(0);
    wr(`REG_STANDBY, {30'h0, `SBY_CMD_HOLD});
    i_wdt_rst <= 1'b1;
    @(posedge i_ref_clk);
    i_wdt_rst <= 1'b0;
    #1;
    wait_for(1);
    cmp_reg(`REG_CTRL, 32'h2);
    wr(`REG_VEC_EN, 32'h3ff);
    wr(`REG_CTRL, 32'h3);
    wr(`REG_STANDBY, {30'h0, `SBY_CMD_XHOLD});
    cmp_port(32'h6e, stops);
    wr(`REG_CTRL, 32'h1);
    cmp_port(32'he, o_osc_stop);
    i_periph_irq.remote_rx <= 1'b1;
    wait_for(1);
    cmp_port(32'h1, o_osc_stop);
    cmp_reg(`REG_WAKE_CAUSE, 32'h10);
    wait_for(0);
    cmp_port(32'h13, o_irq_vector);
    quiet_ret(0);
    $display("standby test done");
    finish_test();
  end
endmodule : priority_irq_and_standby_wake_tb
`default_nettype wire
